// ===== include/adf_map.svh
// Constants for the sample decimator and formatter.
// Assumes inclusion by bare name from include/.
`ifndef ADF_MAP_SVH
`define ADF_MAP_SVH

// Converter word width
`define ADF_CODE_W 8
// Decimation selector width
`define ADF_DEC_SEL_W 3
// Phase counter width, covers ratio 1/128
`define ADF_PHASE_W 7
// Output FIFO depth in words
`define ADF_FIFO_DEPTH 16
// Delay select width and tap limits
`define ADF_DELAY_W 5
`define ADF_TAP_MAX 23
`define ADF_FINE_LAST 6
// Nominal delay steps in picoseconds
`define ADF_FINE_STEP_PS 125
`define ADF_COARSE_STEP_PS 190
// Width of the delay estimate in picoseconds
`define ADF_DELAY_PS_W 12
// Reset values
`define ADF_PHASE_RST 7'h00
`define ADF_CODE_RST 8'h00

`endif

// ===== include/adf_pkg.sv
// Types shared by the decimator, formatter, checker and bench.
// Assumes adf_map.svh is on the include path.
`include "adf_map.svh"

package adf_pkg;
    // One converter sample with its over-range flag
    typedef struct packed {
        logic over_range;
        logic [`ADF_CODE_W-1:0] code;
    } adf_sample_t;

    // Static switch settings
    typedef struct packed {
        logic [`ADF_DEC_SEL_W-1:0] decimation_select;
        logic [3:0] delay_select_low;
        logic delay_select_high;
        logic msb_polarity_select;
        logic low_bits_polarity_select;
        logic dac_output_invert;
    } adf_switch_t;
endpackage

// ===== hdl/adf_decimator_formatter.sv
// Sample decimator, polarity formatter, output FIFO and latches.
// Assumes pins and switches are asynchronous to core_clk and
// that one converter sample arrives per clock edge.
`timescale 1ns/1ns
`default_nettype none
`include "adf_map.svh"

// Word FIFO held in flip-flops
module adf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = `ADF_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    // Storage and pointers
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PW:0] cnt_q, cnt_d;
    logic push, pop;

    // Advance a pointer with wrap
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    // Honest flags from the occupancy count
    assign in_ready = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next pointers, count and storage
    always_comb
    begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            mem_d[wr_q] = in_data;
            wr_d = bump(wr_q);
        end
        if (pop)
        begin
            rd_d = bump(rd_q);
        end
        // Count moves only when one side acts alone
        if (push && !pop)
        begin
            cnt_d = (PW+1)'(cnt_q + 1'b1);
        end
        else if (pop && !push)
        begin
            cnt_d = (PW+1)'(cnt_q - 1'b1);
        end
    end

    // Register FIFO state
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end
endmodule

module adf_decimator_formatter (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire adf_pkg::adf_sample_t adc_sample,
    input wire adf_pkg::adf_switch_t switch_in,
    input wire logic out_ready,
    output adf_pkg::adf_sample_t digital_out_q,
    output adf_pkg::adf_sample_t digital_out_n_q,
    output logic out_valid_q,
    output logic [`ADF_CODE_W-1:0] dac_data_q,
    output logic dec_strobe_q,
    output logic [`ADF_DELAY_W-1:0] delay_tap_q,
    output logic [`ADF_DELAY_PS_W-1:0] delay_ps_q,
    output logic fifo_ready_q,
    output logic overflow_q
);
    import adf_pkg::*;

    // Two-stage synchronisers for pins and switches
    adf_sample_t smp_s1_q, smp_s2_q;
    adf_switch_t sw_s1_q, sw_s2_q;
    // Decimation phase and strobe
    logic [`ADF_PHASE_W-1:0] phase_q, phase_d;
    logic take;
    // Formatted sample entering the FIFO
    adf_sample_t fmt;
    // FIFO handshake
    logic f_in_ready, f_out_valid, f_out_ready;
    logic [$bits(adf_sample_t)-1:0] f_out_data;
    adf_sample_t f_word;
    // Output stage next values
    adf_sample_t dout_d, doutn_d;
    logic oval_d, strobe_d, fready_d, ovf_d;
    logic [`ADF_CODE_W-1:0] dac_d;
    logic [`ADF_DELAY_W-1:0] tap_d;
    logic [`ADF_DELAY_PS_W-1:0] dps_d;

    // Mask of phase bits that must be zero for a take
    function automatic logic [`ADF_PHASE_W-1:0] dec_mask(input logic [`ADF_DEC_SEL_W-1:0] sel);
        logic [`ADF_PHASE_W:0] one_hot;
        one_hot = (`ADF_PHASE_W+1)'(1) << sel;
        return `ADF_PHASE_W'(one_hot - 1'b1);
    endfunction

    // Nominal delay of a tap code in picoseconds
    function automatic logic [`ADF_DELAY_PS_W-1:0] tap_delay(input logic [`ADF_DELAY_W-1:0] code);
        int c;
        c = int'(code);
        if (c > `ADF_TAP_MAX)
        begin
            c = `ADF_TAP_MAX;
        end
        if (c <= `ADF_FINE_LAST)
        begin
            return `ADF_DELAY_PS_W'(c * `ADF_FINE_STEP_PS);
        end
        return `ADF_DELAY_PS_W'(`ADF_FINE_LAST * `ADF_FINE_STEP_PS
                                + (c - `ADF_FINE_LAST) * `ADF_COARSE_STEP_PS);
    endfunction

    // Synchronise asynchronous inputs
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            smp_s1_q <= '0;
            smp_s2_q <= '0;
            sw_s1_q <= '0;
            sw_s2_q <= '0;
        end
        else
        begin
            smp_s1_q <= adc_sample;
            smp_s2_q <= smp_s1_q;
            sw_s1_q <= switch_in;
            sw_s2_q <= sw_s1_q;
        end
    end

    // Phase counter and format of the current sample
    always_comb
    begin
        phase_d = `ADF_PHASE_W'(phase_q + 1'b1);
        take = ((phase_q & dec_mask(sw_s2_q.decimation_select)) == '0);
        fmt.code = {smp_s2_q.code[`ADF_CODE_W-1] ^ sw_s2_q.msb_polarity_select,
                    smp_s2_q.code[`ADF_CODE_W-2:0] ^ {(`ADF_CODE_W-1){sw_s2_q.low_bits_polarity_select}}};
        fmt.over_range = smp_s2_q.over_range;
    end

    // Register decimation phase
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            phase_q <= `ADF_PHASE_RST;
        end
        else
        begin
            phase_q <= phase_d;
        end
    end

    // Buffer between decimator and output latches
    adf_fifo #(
        .WIDTH($bits(adf_sample_t)),
        .DEPTH(`ADF_FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(take),
        .in_ready(f_in_ready),
        .in_data(fmt),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    // Latch may load when empty or when consumer takes it
    assign f_out_ready = !out_valid_q || out_ready;
    assign f_word = adf_sample_t'(f_out_data);

    // Next values of the output latches
    always_comb
    begin
        dout_d = digital_out_q;
        doutn_d = digital_out_n_q;
        dac_d = dac_data_q;
        oval_d = out_valid_q;
        if (f_out_ready)
        begin
            oval_d = f_out_valid;
            if (f_out_valid)
            begin
                dout_d = f_word;
                doutn_d = ~f_word;
                dac_d = ~f_word.code ^ {`ADF_CODE_W{sw_s2_q.dac_output_invert}};
            end
        end
        // Decimated clock as a one-cycle strobe
        strobe_d = take;
        fready_d = f_in_ready;
        // Dropped sample when FIFO is full
        ovf_d = take && !f_in_ready;
        tap_d = {sw_s2_q.delay_select_high, sw_s2_q.delay_select_low};
        dps_d = tap_delay(tap_d);
    end

    // Register output latches and status
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            digital_out_q <= '0;
            digital_out_n_q <= '1;
            dac_data_q <= `ADF_CODE_RST;
            out_valid_q <= 1'b0;
            dec_strobe_q <= 1'b0;
            fifo_ready_q <= 1'b0;
            overflow_q <= 1'b0;
            delay_tap_q <= '0;
            delay_ps_q <= '0;
        end
        else
        begin
            digital_out_q <= dout_d;
            digital_out_n_q <= doutn_d;
            dac_data_q <= dac_d;
            out_valid_q <= oval_d;
            dec_strobe_q <= strobe_d;
            fifo_ready_q <= fready_d;
            overflow_q <= ovf_d;
            delay_tap_q <= tap_d;
            delay_ps_q <= dps_d;
        end
    end
endmodule

`default_nettype wire

// ===== verif/adf_adc_model.sv
// Converter model: a ramp, one new sample per clock.
// Assumes the bench clock; over-range only on request.
`timescale 1ns/1ns
`default_nettype none
module adf_adc_model (
    input wire logic core_clk,
    input wire logic ovr_en,
    output adf_pkg::adf_sample_t sample
);
    import adf_pkg::*;
    logic [7:0] ramp_q = 8'h00; // Ramp value
    always @(posedge core_clk)
    begin
        ramp_q <= #1 ramp_q + 8'h01;
    end
    assign sample = {ovr_en && ramp_q == 8'hff, ramp_q};
endmodule
`default_nettype wire

// ===== verif/adf_decimator_formatter_sva.sv
// Port checker for the decimator and formatter.
// Assumes the top module's ports only.
`timescale 1ns/1ns
`default_nettype none
module adf_decimator_formatter_sva (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire adf_pkg::adf_sample_t adc_sample,
    input wire adf_pkg::adf_switch_t switch_in,
    input wire logic out_ready,
    input wire adf_pkg::adf_sample_t digital_out_q,
    input wire adf_pkg::adf_sample_t digital_out_n_q,
    input wire logic out_valid_q,
    input wire logic [7:0] dac_data_q,
    input wire logic dec_strobe_q,
    input wire logic [4:0] delay_tap_q,
    input wire logic [11:0] delay_ps_q,
    input wire logic fifo_ready_q,
    input wire logic overflow_q
);
    import adf_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_pair_complement: assert property (
        digital_out_n_q == ~digital_out_q) else $error("pair not complement");
    a_dac_complement: assert property (
        $stable(switch_in)[*5] ##0 out_valid_q
        |-> dac_data_q == (~digital_out_q.code ^ {8{switch_in.dac_output_invert}}))
        else $error("dac not complement");
    a_strobe_spacing: assert property (
        ($stable(switch_in)[*6] ##0 switch_in.decimation_select != 3'h0 ##0 dec_strobe_q)
        |=> !dec_strobe_q) else $error("strobe too close");
    a_word_held: assert property (
        out_valid_q && !out_ready |=> out_valid_q && $stable(digital_out_q)) else $error("word lost");
    a_load_after_strobe: assert property (
        $rose(out_valid_q) |-> $past(dec_strobe_q)) else $error("load without strobe");
    a_drop_when_full: assert property (
        overflow_q |-> $past(out_valid_q, 2)) else $error("drop while latch free");
    a_delay_tap: assert property (
        $stable(switch_in)[*5] |-> delay_tap_q == {switch_in.delay_select_high, switch_in.delay_select_low})
        else $error("tap mismatch");
    a_over_top_code: assert property (
        out_valid_q && digital_out_q.over_range |-> digital_out_q.code[6:0] inside {7'h00, 7'h7f})
        else $error("flag off top");
endmodule
bind adf_decimator_formatter adf_decimator_formatter_sva adf_decimator_formatter_sva_i (
    .core_clk(core_clk), .rst_n(rst_n), .adc_sample(adc_sample), .switch_in(switch_in),
    .out_ready(out_ready), .digital_out_q(digital_out_q), .digital_out_n_q(digital_out_n_q),
    .out_valid_q(out_valid_q), .dac_data_q(dac_data_q), .dec_strobe_q(dec_strobe_q),
    .delay_tap_q(delay_tap_q), .delay_ps_q(delay_ps_q), .fifo_ready_q(fifo_ready_q), .overflow_q(overflow_q));
`default_nettype wire

// ===== verif/adf_decimator_formatter_tb.sv
// Bench for the decimator and formatter with a ramp converter.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ns
`default_nettype none
module adf_decimator_formatter_tb;
    import adf_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic out_ready = 1'b1;
    logic ovr_en = 1'b0;
    adf_switch_t sw = '0; // Switch levels
    adf_sample_t smp, dout, dout_n, w0;
    logic oval, strb, frdy, ovf;
    logic [7:0] dac;
    logic [4:0] tap;
    logic [11:0] ps;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int codes[8] = '{0, 1, 6, 7, 10, 23, 24, 31};
    initial forever #50 core_clk = ~core_clk;
    adf_adc_model adf_adc_model_i (.core_clk(core_clk), .ovr_en(ovr_en), .sample(smp));
    adf_decimator_formatter adf_decimator_formatter_i (.core_clk(core_clk), .rst_n(rst_n),
        .adc_sample(smp), .switch_in(sw), .out_ready(out_ready), .digital_out_q(dout),
        .digital_out_n_q(dout_n), .out_valid_q(oval), .dac_data_q(dac), .dec_strobe_q(strb),
        .delay_tap_q(tap), .delay_ps_q(ps), .fifo_ready_q(frdy), .overflow_q(ovf));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #10;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Runs the stream and checks words, spacing and formatting
    task automatic stream(input logic [2:0] sel, input logic [1:0] pol, input logic inv, input int n);
        adf_sample_t w;
        logic [7:0] prev;
        int gap;
        int ns;
        // Polarity levels set once, then static
        sw.decimation_select = sel;
        {sw.msb_polarity_select, sw.low_bits_polarity_select} = pol;
        sw.dac_output_invert = inv;
        step(300);
        for (int k = 0; k < n; k++)
        begin
            gap = 0;
            ns = 0;
            do
            begin
                step(1);
                gap++;
                ns += (strb === 1'b1) ? 1 : 0;
            end while (oval !== 1'b1 && gap < 300);
            w = dout ^ {1'b0, pol[1], {7{pol[0]}}};
            cmp(w.code, 8'(adf_adc_model_i.ramp_q - 8'h04), "word value");
            cmp(dac, 8'(~dout.code ^ {8{inv}}), "dac word");
            cmp(dout_n, adf_sample_t'(~dout), "pair");
            cmp(dout.over_range, ovr_en && w.code == 8'hff, "flag");
            if (k > 0)
                cmp(w.code, 8'(prev + (8'h01 << sel)), "word step");
            if (k > 0)
                cmp(gap, 1 << sel, "spacing");
            if (k > 0)
                cmp(ns, 1, "strobe count");
            prev = w.code;
        end
    endtask
    // Cycle limit cuts a hang short
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end
    initial
    begin
        step(2);
        cmp(dout_n, 9'h1ff, "reset pair");
        cmp(oval, 1'b0, "reset valid");
        step(1);
        rst_n = 1'b1;
        foreach (codes[i])
        begin
            {sw.delay_select_high, sw.delay_select_low} = codes[i][4:0];
            step(6);
            cmp(tap, codes[i], "tap");
            cmp(ps, codes[i] == 0 ? 0 : codes[i] < 7 ? 125 * codes[i]
                : 750 + 190 * ((codes[i] > 23 ? 23 : codes[i]) - 6), "delay");
        end
        {sw.delay_select_high, sw.delay_select_low} = 5'h0a;
        // DAC clock stays under 100 MHz
        for (int s = 0; s < 8; s++)
            stream(s[2:0], s[1:0], s[0], 4);
        ovr_en = 1'b1;
        stream(3'h0, 2'h3, 1'b1, 260);
        out_ready = 1'b0;
        step(3);
        w0 = dout;
        step(40);
        cmp(frdy, 1'b0, "full");
        cmp(ovf, 1'b1, "overflow");
        cmp(dout, w0, "held");
        cmp(tap, 5'h0a, "tap kept");
        out_ready = 1'b1;
        step(30);
        cmp(frdy, 1'b1, "drained");
        cmp(ovf, 1'b0, "no overflow");
        end_of_test();
    end
endmodule
`default_nettype wire
